// ### pidsf_top.sv
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module pidsf_top (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [5:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output      logic [31:0]                   wb_dat_o,
  output      logic                          wb_ack_o,
  input  wire logic                          sample_tick,
  input  wire logic signed [pidsf_pkg::POS_W-1:0] cmd_position,
  input  wire logic signed [pidsf_pkg::POS_W-1:0] cmd_speed,
  input  wire pidsf_pkg::pidsf_phase_t       profile_phase,
  input  wire logic [pidsf_pkg::POS_W-1:0]   encoder_position,
  output      logic signed [pidsf_pkg::OUT_W-1:0] motor_command_output,
  output      logic                          command_valid
);
  import pidsf_pkg::*;

  // ****************************************
  // Encoder pin synchroniser
  // ****************************************
  logic [POS_W-1:0] enc_s1_reg, enc_s2_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enc_s1_reg <= '0;
      enc_s2_reg <= '0;
    end else begin
      enc_s1_reg <= encoder_position;
      enc_s2_reg <= enc_s1_reg;
    end
  end

  // ****************************************
  // Register file and bus slave
  // ****************************************
  pidsf_cfg_t  cfg_reg, cfg_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic signed [POS_W-1:0] err_reg;
  logic        int_en_reg;
  logic        sat_hi_reg, sat_lo_reg;

  function automatic logic [GAIN_W-1:0] merge16(input logic [GAIN_W-1:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
    logic [GAIN_W-1:0] r;
    r = old;
    if (sel[0]) r[7:0]  = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction

  always_comb begin
    logic req;
    logic wr;
    req       = wb_cyc_i && wb_stb_i && !ack_reg;
    // Write lands at the edge that samples ack
    wr        = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    cfg_next  = cfg_reg;
    ack_next  = req;
    rdat_next = '0;
    if (wr) begin
      case (wb_adr_i & 6'h3c)
        PROPORTIONAL_GAIN_OFS:        cfg_next.proportional_gain        = merge16(cfg_reg.proportional_gain, wb_dat_i, wb_sel_i);
        DERIVATIVE_GAIN_OFS:          cfg_next.derivative_gain          = merge16(cfg_reg.derivative_gain, wb_dat_i, wb_sel_i);
        INTEGRAL_GAIN_OFS:            cfg_next.integral_gain            = merge16(cfg_reg.integral_gain, wb_dat_i, wb_sel_i);
        INTEGRATOR_LIMIT_OFS:         cfg_next.integrator_limit         = merge16(cfg_reg.integrator_limit, wb_dat_i, wb_sel_i);
        VELOCITY_FEEDFORWARD_OFS:     cfg_next.velocity_feedforward     = merge16(cfg_reg.velocity_feedforward, wb_dat_i, wb_sel_i);
        ACCELERATION_FEEDFORWARD_OFS: cfg_next.acceleration_feedforward = merge16(cfg_reg.acceleration_feedforward, wb_dat_i, wb_sel_i);
        OUTPUT_BIAS_OFS:              cfg_next.output_bias              = merge16(cfg_reg.output_bias, wb_dat_i, wb_sel_i);
        RAMP_UP_RATE_OFS:             cfg_next.ramp_up_rate             = merge16(cfg_reg.ramp_up_rate, wb_dat_i, wb_sel_i);
        RAMP_DOWN_RATE_OFS:           cfg_next.ramp_down_rate           = merge16(cfg_reg.ramp_down_rate, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i & 6'h3c)
        PROPORTIONAL_GAIN_OFS:        rdat_next[GAIN_W-1:0] = cfg_reg.proportional_gain;
        DERIVATIVE_GAIN_OFS:          rdat_next[GAIN_W-1:0] = cfg_reg.derivative_gain;
        INTEGRAL_GAIN_OFS:            rdat_next[GAIN_W-1:0] = cfg_reg.integral_gain;
        INTEGRATOR_LIMIT_OFS:         rdat_next[GAIN_W-1:0] = cfg_reg.integrator_limit;
        VELOCITY_FEEDFORWARD_OFS:     rdat_next[GAIN_W-1:0] = cfg_reg.velocity_feedforward;
        ACCELERATION_FEEDFORWARD_OFS: rdat_next[GAIN_W-1:0] = cfg_reg.acceleration_feedforward;
        OUTPUT_BIAS_OFS:              rdat_next[GAIN_W-1:0] = cfg_reg.output_bias;
        RAMP_UP_RATE_OFS:             rdat_next[GAIN_W-1:0] = cfg_reg.ramp_up_rate;
        RAMP_DOWN_RATE_OFS:           rdat_next[GAIN_W-1:0] = cfg_reg.ramp_down_rate;
        ERROR_REPORT_OFS:             rdat_next = err_reg;
        OUTPUT_REPORT_OFS:            rdat_next[OUT_W-1:0] = motor_command_output;
        STATUS_OFS: begin
          rdat_next[STATUS_INT_EN_BIT] = int_en_reg;
          rdat_next[STATUS_SAT_HI_BIT] = sat_hi_reg;
          rdat_next[STATUS_SAT_LO_BIT] = sat_lo_reg;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg  <= CFG_RESET;
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end else begin
      cfg_reg  <= cfg_next;
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ****************************************
  // Stage A: error, derivative, integrator
  // ****************************************
  logic signed [POS_W-1:0] err_next;
  logic signed [POS_W:0]   derr_reg, derr_next;
  logic signed [ACC_W-1:0] acc_reg, acc_next, acc_sum;
  logic signed [POS_W-1:0] speed_reg, speed_next;
  pidsf_phase_t            phase_reg, phase_next;
  logic                    stage_b_reg, int_en_next;
  logic                    acc_hi, acc_lo;
  logic                    move_active;

  assign move_active = (profile_phase != PHASE_IDLE);

  pidsf_sat #(.IN_W(ACC_W+1), .OUT_W(ACC_W)) u_acc_sat (
    .din    ((ACC_W+1)'(acc_reg) + (ACC_W+1)'(err_next)),
    .dout   (acc_sum),
    .sat_hi (acc_hi),
    .sat_lo (acc_lo)
  );

  always_comb begin
    err_next    = err_reg;
    derr_next   = derr_reg;
    acc_next    = acc_reg;
    speed_next  = speed_reg;
    phase_next  = phase_reg;
    int_en_next = int_en_reg;
    if (sample_tick) begin
      err_next    = cmd_position - $signed(enc_s2_reg);
      derr_next   = (POS_W+1)'(err_next) - (POS_W+1)'(err_reg);
      speed_next  = cmd_speed;
      phase_next  = profile_phase;
      int_en_next = !(cfg_reg.integrator_limit < 0 && move_active);
      if (!int_en_next) begin
        acc_next = '0;
      end else if ((sat_hi_reg && err_next > 0) || (sat_lo_reg && err_next < 0)) begin
        acc_next = acc_reg;
      end else begin
        acc_next = acc_sum;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_reg     <= '0;
      derr_reg    <= '0;
      acc_reg     <= '0;
      speed_reg   <= '0;
      phase_reg   <= PHASE_IDLE;
      int_en_reg  <= 1'b1;
      stage_b_reg <= 1'b0;
    end else begin
      err_reg     <= err_next;
      derr_reg    <= derr_next;
      acc_reg     <= acc_next;
      speed_reg   <= speed_next;
      phase_reg   <= phase_next;
      int_en_reg  <= int_en_next;
      stage_b_reg <= sample_tick;
    end
  end

  // ****************************************
  // Stage B: term sum and output saturation
  // ****************************************
  logic signed [SUM_W-1:0] p_term, d_term, i_raw, i_term, v_term, a_term, lim, total;
  logic signed [OUT_W-1:0] out_sat, out_next;
  logic                    out_hi, out_lo, sat_hi_next, sat_lo_next, valid_next;

  pidsf_sat #(.IN_W(SUM_W), .OUT_W(OUT_W)) u_out_sat (
    .din    (total),
    .dout   (out_sat),
    .sat_hi (out_hi),
    .sat_lo (out_lo)
  );

  always_comb begin
    p_term = SUM_W'(cfg_reg.proportional_gain) * SUM_W'(err_reg);
    d_term = SUM_W'(cfg_reg.derivative_gain) * SUM_W'(derr_reg);
    v_term = SUM_W'(cfg_reg.velocity_feedforward) * SUM_W'(speed_reg);
    a_term = '0;
    if (phase_reg == PHASE_ACCEL) begin
      a_term = SUM_W'(cfg_reg.acceleration_feedforward) * SUM_W'(cfg_reg.ramp_up_rate);
    end else if (phase_reg == PHASE_DECEL) begin
      a_term = -(SUM_W'(cfg_reg.acceleration_feedforward) * SUM_W'(cfg_reg.ramp_down_rate));
    end
    if (speed_reg < 0) begin
      a_term = -a_term;
    end
    i_raw  = (SUM_W'(cfg_reg.integral_gain) * SUM_W'(acc_reg)) >>> FRAC_W;
    lim    = SUM_W'(cfg_reg.integrator_limit);
    i_term = i_raw;
    if (!int_en_reg) begin
      i_term = '0;
    end else if (lim > 0 && i_raw > lim) begin
      i_term = lim;
    end else if (lim > 0 && i_raw < -lim) begin
      i_term = -lim;
    end
    total = ((p_term + d_term + v_term + a_term) >>> FRAC_W) + i_term
            + SUM_W'(cfg_reg.output_bias);
    out_next    = motor_command_output;
    sat_hi_next = sat_hi_reg;
    sat_lo_next = sat_lo_reg;
    valid_next  = stage_b_reg;
    if (stage_b_reg) begin
      out_next    = out_sat;
      sat_hi_next = out_hi;
      sat_lo_next = out_lo;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      motor_command_output <= '0;
      sat_hi_reg           <= 1'b0;
      sat_lo_reg           <= 1'b0;
      command_valid        <= 1'b0;
    end else begin
      motor_command_output <= out_next;
      sat_hi_reg           <= sat_hi_next;
      sat_lo_reg           <= sat_lo_next;
      command_valid        <= valid_next;
    end
  end

endmodule // pidsf_top

// ### pidsf_pkg.sv
package pidsf_pkg;

  // ****************************************
  // Widths and scaling
  // ****************************************
  localparam int POS_W    = 32;
  localparam int GAIN_W   = 16;
  localparam int OUT_W    = 16;
  localparam int ACC_W    = 40;
  localparam int SUM_W    = 64;
  localparam int FRAC_W   = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] PROPORTIONAL_GAIN_OFS        = 6'h00;
  localparam logic [5:0] DERIVATIVE_GAIN_OFS          = 6'h04;
  localparam logic [5:0] INTEGRAL_GAIN_OFS            = 6'h08;
  localparam logic [5:0] INTEGRATOR_LIMIT_OFS         = 6'h0c;
  localparam logic [5:0] VELOCITY_FEEDFORWARD_OFS     = 6'h10;
  localparam logic [5:0] ACCELERATION_FEEDFORWARD_OFS = 6'h14;
  localparam logic [5:0] OUTPUT_BIAS_OFS              = 6'h18;
  localparam logic [5:0] RAMP_UP_RATE_OFS             = 6'h1c;
  localparam logic [5:0] RAMP_DOWN_RATE_OFS           = 6'h20;
  localparam logic [5:0] ERROR_REPORT_OFS             = 6'h24;
  localparam logic [5:0] OUTPUT_REPORT_OFS            = 6'h28;
  localparam logic [5:0] STATUS_OFS                   = 6'h2c;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int STATUS_INT_EN_BIT = 0;
  localparam int STATUS_SAT_HI_BIT = 1;
  localparam int STATUS_SAT_LO_BIT = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_ACCEL,
    PHASE_CRUISE,
    PHASE_DECEL
  } pidsf_phase_t;

  typedef struct packed {
    logic signed [GAIN_W-1:0] proportional_gain;
    logic signed [GAIN_W-1:0] derivative_gain;
    logic signed [GAIN_W-1:0] integral_gain;
    logic signed [GAIN_W-1:0] integrator_limit;
    logic signed [GAIN_W-1:0] velocity_feedforward;
    logic signed [GAIN_W-1:0] acceleration_feedforward;
    logic signed [GAIN_W-1:0] output_bias;
    logic signed [GAIN_W-1:0] ramp_up_rate;
    logic signed [GAIN_W-1:0] ramp_down_rate;
  } pidsf_cfg_t;

  localparam pidsf_cfg_t CFG_RESET = '0;

endpackage

// ### pidsf_sat.sv
`timescale 1ns/100ps
module pidsf_sat #(
  parameter int IN_W  = 65,
  parameter int OUT_W = 16
) (
  input  wire logic signed [IN_W-1:0]  din,
  output      logic signed [OUT_W-1:0] dout,
  output      logic                    sat_hi,
  output      logic                    sat_lo
);
  localparam logic signed [IN_W-1:0] MAXV = {{(IN_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
  localparam logic signed [IN_W-1:0] MINV = {{(IN_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};

  always_comb begin
    sat_hi = (din > MAXV);
    sat_lo = (din < MINV);
    if (sat_hi) begin
      dout = MAXV[OUT_W-1:0];
    end else if (sat_lo) begin
      dout = MINV[OUT_W-1:0];
    end else begin
      dout = din[OUT_W-1:0];
    end
  end
endmodule // pidsf_sat

// ### pidsf_properties.sv
`timescale 1ns/100ps
module pidsf_properties (
  input wire logic                            core_clk,
  input wire logic                            sys_rst,
  input wire logic                            wb_cyc_i,
  input wire logic                            wb_stb_i,
  input wire logic                            wb_we_i,
  input wire logic [5:0]                      wb_adr_i,
  input wire logic [31:0]                     wb_dat_o,
  input wire logic                            wb_ack_o,
  input wire logic                            sample_tick,
  input wire logic signed [pidsf_pkg::OUT_W-1:0] motor_command_output,
  input wire logic                            command_valid
);
  import pidsf_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_valid_delay: assert property (sample_tick |-> ##2 command_valid)
    else $error("no command two cycles after sample");
  a_valid_cause: assert property (command_valid |-> $past(sample_tick, 2))
    else $error("command without a sample");
  a_out_hold: assert property (!command_valid |-> $stable(motor_command_output))
    else $error("command changed without valid");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] != ERROR_REPORT_OFS[5:2]
    |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  c_tick: cover property (command_valid);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_read: cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
endmodule // pidsf_properties

bind pidsf_top pidsf_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_tick(sample_tick), .motor_command_output(motor_command_output), .command_valid(command_valid));

// ### pidsf_amp_model.sv
`timescale 1ns/100ps
module pidsf_amp_model (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              move_en,
  input  wire logic signed [pidsf_pkg::OUT_W-1:0] motor_command_output,
  input  wire logic                              command_valid,
  output      logic [pidsf_pkg::POS_W-1:0]       encoder_position
);
  import pidsf_pkg::*;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  always_comb begin
    pos_next = pos_reg;
    // Shaft follows the drive only when enabled
    if (move_en && command_valid) begin
      pos_next = pos_reg + POS_W'(motor_command_output >>> 6);
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_reg <= '0;
    end else begin
      pos_reg <= pos_next;
    end
  end
  assign encoder_position = pos_reg;
endmodule // pidsf_amp_model

// ### pid_servo_filter_tb.sv
`timescale 1ns/100ps
module pid_servo_filter_tb;
  import pidsf_pkg::*;
  logic core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sample_tick, command_valid, move_en;
  logic [5:0]               wb_adr_i;
  logic [3:0]               wb_sel_i;
  logic [31:0]              wb_dat_i, wb_dat_o, rnd, seed;
  logic signed [POS_W-1:0]  cmd_position, cmd_speed;
  logic [POS_W-1:0]         encoder_position;
  logic signed [OUT_W-1:0]  motor_command_output;
  pidsf_phase_t             profile_phase;
  int                       err_count, check_count;
  longint                   g[9], acc, pe, le;
  bit                       shi, slo;
  logic [31:0]              rq[$];
  logic [15:0]              oq[$];

  pidsf_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_tick(sample_tick), .cmd_position(cmd_position), .cmd_speed(cmd_speed),
    .profile_phase(profile_phase), .encoder_position(encoder_position),
    .motor_command_output(motor_command_output), .command_valid(command_valid));
  pidsf_amp_model u_amp (.core_clk(core_clk), .sys_rst(sys_rst), .move_en(move_en),
    .motor_command_output(motor_command_output), .command_valid(command_valid),
    .encoder_position(encoder_position));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_out(input logic [15:0] e, input logic [15:0] got);
    check_count++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] got);
    check_count++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask

  always @(posedge core_clk) begin
    if (command_valid === 1'b1) begin
      if (oq.size() > 0) cmp_out(oq.pop_front(), motor_command_output);
      else err_count++;
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rq.size() > 0) cmp_rd(rq.pop_front(), wb_dat_o);
      else err_count++;
    end
  end

  // ****
  // Bus and sample drivers
  // ****
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic cfg(input int r, input longint v);
    g[r] = v;
    bus(1'b1, 6'(r * 4), 32'(v));
  endtask

  task automatic setg(input longint v[9]);
    for (int r = 0; r < 9; r++) cfg(r, v[r]);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic tick(input longint p, input longint s, input pidsf_phase_t ph);
    longint e, de, i, a, o;
    bit off;
    e = p - longint'($signed(encoder_position));
    de = e - pe;
    pe = e;
    le = e;
    off = g[3] < 0 && ph != PHASE_IDLE;
    if (off) acc = 0;
    else if (!(shi && e > 0) && !(slo && e < 0)) acc += e;
    i = off ? 0 : (g[2] * acc) >>> 8;
    if (g[3] > 0 && i > g[3]) i = g[3];
    if (g[3] > 0 && i < -g[3]) i = -g[3];
    a = ph == PHASE_ACCEL ? g[5] * g[7] : ph == PHASE_DECEL ? -g[5] * g[8] : 0;
    if (s < 0) a = -a;
    o = ((g[0] * e + g[1] * de + g[4] * s + a) >>> 8) + i + g[6];
    shi = o > 32767;
    slo = o < -32768;
    oq.push_back(16'(shi ? 32767 : slo ? -32768 : o));
    sample_tick <= 1'b1;
    cmd_position <= 32'(p);
    cmd_speed <= 32'(s);
    profile_phase <= ph;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, sample_tick, move_en} = 6'h20;
    {wb_adr_i, wb_dat_i, cmd_position, cmd_speed} = '0;
    wb_sel_i = 4'hf;
    profile_phase = PHASE_IDLE;
    {err_count, check_count, acc, pe, le, shi, slo} = '0;
    seed = 32'h9fa2;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(STATUS_OFS, 32'h1);
    for (int r = 0; r < 9; r++) begin
      rnd = xs();
      cfg(r, longint'($signed(rnd[15:0])));
      rd(6'(r * 4), {16'h0, rnd[15:0]});
    end
    rd(6'h30, 32'h0);
    bus(1'b1, OUTPUT_REPORT_OFS, 32'h1234);
    rd(OUTPUT_REPORT_OFS, 32'h0);
    $display("test registers done");
    setg('{256, 128, 0, 0, 0, 0, 100, 0, 0});
    repeat (8) begin
      rnd = xs();
      tick(longint'($signed(rnd[11:0])), 0, PHASE_IDLE);
    end
    rd(ERROR_REPORT_OFS, 32'(le));
    $display("test proportional derivative done");
    setg('{0, 0, 64, 0, 0, 0, 0, 0, 0});
    repeat (6) tick(50, 0, PHASE_IDLE);
    cfg(3, 20);
    repeat (3) tick(50, 0, PHASE_IDLE);
    repeat (4) tick(-200, 0, PHASE_IDLE);
    $display("test integral done");
    setg('{0, 0, 64, -1, 0, 0, 0, 0, 0});
    repeat (3) tick(40, 0, PHASE_ACCEL);
    repeat (3) tick(40, 0, PHASE_IDLE);
    $display("test integral suspend done");
    setg('{0, 0, 0, 0, 32, 16, 0, 100, 50});
    for (int ph = 0; ph < 4; ph++) begin
      tick(30, 200, pidsf_phase_t'(ph));
      tick(-30, 200, pidsf_phase_t'(ph));
      tick(-30, -200, pidsf_phase_t'(ph));
    end
    $display("test feedforward done");
    setg('{32767, 0, 0, 0, 0, 0, 0, 0, 0});
    tick(100000, 0, PHASE_IDLE);
    tick(100000, 0, PHASE_IDLE);
    tick(-100000, 0, PHASE_IDLE);
    rd(OUTPUT_REPORT_OFS, 32'h8000);
    rd(STATUS_OFS, 32'h5);
    $display("test saturation done");
    setg('{256, 64, 16, 0, 0, 0, 0, 0, 0});
    move_en <= 1'b1;
    repeat (10) tick(500, 0, PHASE_IDLE);
    move_en <= 1'b0;
    $display("test closed loop done");
    repeat (5) @(posedge core_clk);
    if (oq.size() > 0 || rq.size() > 0) err_count++;
    end_of_test();
  end
endmodule // pid_servo_filter_tb
